// ### core/bpq_pkg.sv
// constants, types and register map of the battery protection qualifier
package bpq_pkg;
  // timing
  localparam int CLK_HZ      = 20_000_000;  // system clock rate
  localparam int TICK_MS     = 100;         // base tick period in ms
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_S = 10;          // 0.1 s ticks per second
  localparam int S_PER_H     = 3600;        // seconds per hour
  localparam int CONV_HOLD_S = 10;          // recovery hold time in s
  localparam logic [7:0] CONV_HYST = 8'h0A; // 0.1 V in 0.01 V codes
  // parameter bank, printed offsets are word indices
  localparam int NPARAM = 16;
  localparam logic [7:0] IDX_PRECHG  = 8'h3C;
  localparam logic [7:0] IDX_CLIMATE = 8'h48;
  localparam logic [7:0] IDX_INS_ON  = 8'h49;
  localparam logic [7:0] IDX_INS_OFF = 8'h4A;
  localparam logic [7:0] IDX_HT_ONT  = 8'h4B;
  localparam logic [7:0] IDX_HT_OFFT = 8'h4C;
  localparam logic [7:0] IDX_HT_ON   = 8'h4D;
  localparam logic [7:0] IDX_HT_OFF  = 8'h4E;
  localparam logic [7:0] IDX_RD_ONT  = 8'h4F;
  localparam logic [7:0] IDX_RD_OFFT = 8'h50;
  localparam logic [7:0] IDX_RD_ON   = 8'h51;
  localparam logic [7:0] IDX_RD_OFF  = 8'h52;
  localparam logic [7:0] IDX_CONV    = 8'h60;
  localparam logic [7:0] IDX_CS_ON   = 8'h61;
  localparam logic [7:0] IDX_CS_OFF  = 8'h62;
  localparam logic [7:0] IDX_COMM    = 8'h63;
  localparam logic [7:0] PARAM_IDX [NPARAM] = '{IDX_PRECHG, IDX_CLIMATE,
    IDX_INS_ON, IDX_INS_OFF, IDX_HT_ONT, IDX_HT_OFFT, IDX_HT_ON,
    IDX_HT_OFF, IDX_RD_ONT, IDX_RD_OFFT, IDX_RD_ON, IDX_RD_OFF,
    IDX_CONV, IDX_CS_ON, IDX_CS_OFF, IDX_COMM};
  localparam logic [7:0] PARAM_RST = 8'h00;  // value after reset
  // block registers, word indices
  localparam logic [7:0] IDX_CTRL = 8'h70;
  localparam logic [7:0] IDX_STAT = 8'h71;
  localparam logic [7:0] IDX_IRQ  = 8'h72;
  localparam logic [7:0] IDX_MASK = 8'h73;
  localparam int CTRL_CLOSE = 0;  // request pack close
  localparam int CTRL_RESTORE = 1;  // comm restore feature enable
  // debounced protections
  localparam int NPROT = 4;
  localparam int PR_INS = 0;
  localparam int PR_HEAT = 1;
  localparam int PR_RED = 2;
  localparam int PR_CUR = 3;
  // status bits above the protections
  localparam int ST_CONV = 4;
  localparam int ST_PRE = 5;
  localparam int ST_MAIN = 6;
  localparam int ST_CERR = 7;
  localparam int ST_CLIM = 8;
  // interrupt bits, 0..3 are protection activations
  localparam int NIRQ = 7;
  localparam int IRQ_CONV = 4;
  localparam int IRQ_CERR = 5;
  localparam int IRQ_CLIM = 6;
  localparam logic [31:0] IRQ_RST = 32'h00000000;

  typedef logic [NPARAM-1:0][7:0] param_bank_t;

  // measurement inputs
  typedef struct packed {
    logic [7:0] temp_max;    // hottest cell, 1 C steps, offset -100
    logic [7:0] volt_min;    // lowest cell, 0.01 V steps, offset 200
    logic       ins_fault;   // insulation fault seen
    logic       cur_missing; // current sensor absent
    logic       charger;     // charger session active
    logic       ignition;    // ignition input active
    logic       comm_lost;   // no cell communication
    logic       climate_req; // climate control wanted
  } meas_t;

  typedef enum logic [2:0] {
    PK_OPEN = 3'b001,
    PK_PRE  = 3'b010,
    PK_MAIN = 3'b100
  } pack_t;
endpackage : bpq_pkg

// ### core/param_bank.sv
// byte-wide parameter bank with registered read port
`timescale 1ns/100ps
module param_bank (
  // clock and reset
  input  wire logic                 CLOCK_I,
  input  wire logic                 RST_I,
  // write port
  input  wire logic                 WE_I,
  input  wire logic [3:0]           WSLOT_I,
  input  wire logic [7:0]           WDATA_I,
  // read port
  input  wire logic [3:0]           RSLOT_I,
  output logic      [7:0]           RDATA_O,
  // all words for the qualifier logic
  output bpq_pkg::param_bank_t      BANK_O
);
  import bpq_pkg::*;

  typedef struct packed {
    param_bank_t bank;   // stored words
    logic [7:0]  rdata;  // read register
  } bank_state_t;

  bank_state_t st;       // current state
  bank_state_t next_st;  // next state

  // write and read, read data always registered
  always_comb begin
    next_st = st;
    next_st.rdata = st.bank[RSLOT_I];
    if (WE_I) begin
      next_st.bank[WSLOT_I] = WDATA_I;
    end
  end

  // registers, all words cleared on reset
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      st <= '{bank: {NPARAM{PARAM_RST}}, rdata: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign RDATA_O = st.rdata;
  assign BANK_O  = st.bank;
endmodule : param_bank

// ### core/battery_protection_qualifier.sv
// protection qualifier: debounce, contactor, climate and converter logic
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
module battery_protection_qualifier #(
  parameter int TICK_CYCLES = bpq_pkg::TICK_CYCLES  // clocks per 0.1 s
) (
  // clock and reset
  input  wire logic                 CLOCK_I,
  input  wire logic                 RST_I,
  // apb slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [11:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic                      PREADY,
  output logic      [31:0]          PRDATA,
  output logic                      PSLVERR,
  // measurements
  input  wire bpq_pkg::meas_t       MEAS_I,
  // contactor and load outputs
  output logic                      PRECHARGE_O,
  output logic                      MAIN_CONTACTOR_O,
  output logic                      CONVERTER_ENABLE_OUT_O,
  output logic                      CLIMATE_O,
  output logic                      CHARGE_ATTEMPT_O,
  output logic                      CHARGE_ERROR_O,
  output logic      [3:0]           PROTECT_O,
  // interrupt
  output logic                      IRQ_O
);
  import bpq_pkg::*;

  // refuse prescaler lengths the counter cannot hold
  if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << 24)) begin : g_chk
    $error("TICK_CYCLES out of range");
  end

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
  localparam logic [3:0]  SEC_LAST  = 4'(TICKS_PER_S - 1);
  localparam logic [11:0] HOUR_LAST = 12'(S_PER_H - 1);
  localparam logic [3:0]  CONV_HOLD = 4'(CONV_HOLD_S);

  // map a word index to a parameter slot, bit 4 flags a hit
  function automatic logic [4:0] param_slot(input logic [7:0] idx);
    logic [4:0] res;
    res = 5'h00;
    for (int k = 0; k < NPARAM; k++) begin
      if (PARAM_IDX[k] == idx) begin
        res = {1'b1, 4'(k)};
      end
    end
    return res;
  endfunction : param_slot

  // word index of a byte address, low bits must be zero
  function automatic logic [7:0] word_idx(input logic [11:0] addr);
    return (addr[1:0] == 2'b00 && addr[11:10] == 2'b00)
           ? addr[9:2] : 8'hFF;
  endfunction : word_idx

  // threshold compare with hysteresis: set at or above the on code,
  // held while above the off code, so a noisy reading cannot chatter
  function automatic logic hyst_cmp(input logic       active,
                                    input logic [7:0] value,
                                    input logic [7:0] on_code,
                                    input logic [7:0] off_code);
    return active ? (value > off_code) : (value >= on_code);
  endfunction : hyst_cmp

  typedef struct packed {
    logic [23:0]            pre_cnt;   // clocks within 0.1 s
    logic [3:0]             sec_cnt;   // 0.1 s ticks within 1 s
    logic [11:0]            hr_cnt;    // seconds within 1 h
    logic [NPROT-1:0]       prot;      // debounced protections
    logic [NPROT-1:0][7:0]  dly;       // debounce delay counters
    pack_t                  pack;      // contactor sequence
    logic [7:0]             pk_cnt;    // precharge seconds
    logic [7:0]             clim_cnt;  // hours without charging
    logic                   clim_stop; // climate time used up
    logic                   conv_on;   // converter enable
    logic [3:0]             conv_cnt;  // recovery seconds
    logic [7:0]             comm_cnt;  // restore seconds
    logic                   cerr;      // charging error
    logic                   clim_out;  // climate pin register
    logic                   att_out;   // charge attempt pin register
    logic [1:0]             ctrl;      // control register
    logic [NIRQ-1:0]        irq;       // sticky events
    logic [NIRQ-1:0]        mask;      // interrupt mask
    logic [31:0]            rd_own;    // latched own read word
    logic                   rd_mem;    // read served by bank
  } state_t;

  state_t      st;         // current state
  state_t      next_st;    // next state
  param_bank_t par;        // all parameters
  logic [7:0]  bank_rd;    // bank read word
  logic [7:0]  idx;        // addressed word index
  logic [4:0]  slot;       // decoded parameter slot
  logic        own_hit;    // block register addressed
  logic        setup;      // apb setup cycle
  logic        access;     // apb access cycle, completes now
  logic        tick_ds;    // 0.1 s tick
  logic        tick_s;     // 1 s tick
  logic        tick_h;     // 1 h tick
  logic [NPROT-1:0] cond;  // raw protection conditions
  logic [NPROT-1:0][7:0] on_lim;   // activation delays
  logic [NPROT-1:0][7:0] off_lim;  // deactivation delays
  logic        passive;    // no charger, no ignition
  logic [8:0]  conv_up;    // threshold plus hysteresis
  logic [NIRQ-1:0] ev;     // events this cycle
  logic [31:0] stat;       // live status word

  param_bank u_bank (
    .CLOCK_I (CLOCK_I),
    .RST_I   (RST_I),
    .WE_I    (access && PWRITE && slot[4]),
    .WSLOT_I (slot[3:0]),
    .WDATA_I (PWDATA[7:0]),
    .RSLOT_I (slot[3:0]),
    .RDATA_O (bank_rd),
    .BANK_O  (par)
  );

  // address decode, shared by setup and access phases
  always_comb begin
    idx     = word_idx(PADDR);
    slot    = param_slot(idx);
    own_hit = idx == IDX_CTRL || idx == IDX_STAT ||
              idx == IDX_IRQ || idx == IDX_MASK;
    setup   = PSEL && !PENABLE;
    access  = PSEL && PENABLE;
  end

  // delay limits and raw conditions with threshold hysteresis
  always_comb begin
    on_lim[PR_INS]  = par[3'd2];
    off_lim[PR_INS] = par[3'd3];
    on_lim[PR_HEAT] = par[4'd6];
    off_lim[PR_HEAT] = par[4'd7];
    on_lim[PR_RED]  = par[4'd10];
    off_lim[PR_RED] = par[4'd11];
    on_lim[PR_CUR]  = par[4'd13];
    off_lim[PR_CUR] = par[4'd14];
    cond[PR_INS] = MEAS_I.ins_fault;
    // active: hold until at or below release level
    cond[PR_HEAT] = hyst_cmp(st.prot[PR_HEAT], MEAS_I.temp_max,
                             par[3'd4], par[3'd5]);
    // reduction uses its own pair of codes
    cond[PR_RED] = hyst_cmp(st.prot[PR_RED], MEAS_I.temp_max,
                            par[4'd8], par[4'd9]);
    cond[PR_CUR] = MEAS_I.cur_missing;
    passive = !MEAS_I.charger && !MEAS_I.ignition;
    conv_up = {1'b0, par[4'd12]} + {1'b0, CONV_HYST};
  end

  // live status word
  always_comb begin
    stat = 32'h00000000;
    stat[NPROT-1:0] = st.prot;
    stat[ST_CONV] = st.conv_on;
    stat[ST_PRE]  = st.pack == PK_PRE;
    stat[ST_MAIN] = st.pack == PK_MAIN;
    stat[ST_CERR] = st.cerr;
    stat[ST_CLIM] = !st.clim_stop;
  end

  // whole next state
  always_comb begin
    next_st = st;
    ev = '0;
    // prescaler: one clock only, slower rates are enables
    // ticks free-run from reset, so the first unit of any delay is short
    tick_ds = st.pre_cnt == TICK_LAST;
    tick_s  = tick_ds && st.sec_cnt == SEC_LAST;
    tick_h  = tick_s && st.hr_cnt == HOUR_LAST;
    next_st.pre_cnt = tick_ds ? 24'h000000 : st.pre_cnt + 24'h000001;
    if (tick_ds) begin
      next_st.sec_cnt = tick_s ? 4'h0 : st.sec_cnt + 4'h1;
    end
    if (tick_s) begin
      next_st.hr_cnt = tick_h ? 12'h000 : st.hr_cnt + 12'h001;
    end

    // debounce: on delay in 0.1 s, off delay in 1 s
    // a delay of zero acts on the cycle after the condition changes
    for (int i = 0; i < NPROT; i++) begin
      if (cond[i] == st.prot[i]) begin
        // condition matches output, any partial delay is lost
        next_st.dly[i] = 8'h00;
      end else if (!st.prot[i]) begin
        if (st.dly[i] >= on_lim[i]) begin
          next_st.prot[i] = 1'b1;
          next_st.dly[i]  = 8'h00;
          ev[i] = 1'b1;
        end else if (tick_ds) begin
          next_st.dly[i] = st.dly[i] + 8'h01;
        end
      end else begin
        if (st.dly[i] >= off_lim[i]) begin
          next_st.prot[i] = 1'b0;
          next_st.dly[i]  = 8'h00;
        end else if (tick_s) begin
          next_st.dly[i] = st.dly[i] + 8'h01;
        end
      end
    end

    // contactor sequence, opens on request drop or insulation fault
    // the precharge count restarts on every entry, so a reopened pack
    // always counts every precharge second again, the first one short
    unique case (st.pack)
      PK_OPEN: begin
        if (st.ctrl[CTRL_CLOSE] && !st.prot[PR_INS]) begin
          next_st.pack   = PK_PRE;
          next_st.pk_cnt = 8'h00;
        end
      end
      PK_PRE: begin
        if (!st.ctrl[CTRL_CLOSE] || st.prot[PR_INS]) begin
          next_st.pack = PK_OPEN;
        end else if (st.pk_cnt >= par[3'd0]) begin
          next_st.pack = PK_MAIN;
        end else if (tick_s) begin
          next_st.pk_cnt = st.pk_cnt + 8'h01;
        end
      end
      PK_MAIN: begin
        if (!st.ctrl[CTRL_CLOSE] || st.prot[PR_INS]) begin
          next_st.pack = PK_OPEN;
        end
      end
      default: next_st.pack = PK_OPEN;
    endcase

    // climate time limit while not charging, in hours
    if (MEAS_I.charger) begin
      next_st.clim_cnt  = 8'h00;
      next_st.clim_stop = 1'b0;
    end else if (!st.clim_stop) begin
      if (st.clim_cnt >= par[3'd1]) begin
        next_st.clim_stop = 1'b1;
        ev[IRQ_CLIM] = 1'b1;
      end else if (tick_h) begin
        next_st.clim_cnt = st.clim_cnt + 8'h01;
      end
    end

    // climate pin registered; follows request until time is used up
    next_st.clim_out = MEAS_I.climate_req && !next_st.clim_stop;

    // converter enable with voltage hysteresis in passive state
    if (!passive) begin
      next_st.conv_on  = 1'b1;
      next_st.conv_cnt = 4'h0;
    end else if (st.conv_on) begin
      if (MEAS_I.volt_min < par[4'd12]) begin
        next_st.conv_on  = 1'b0;
        next_st.conv_cnt = 4'h0;
        ev[IRQ_CONV] = 1'b1;
      end
    end else if ({1'b0, MEAS_I.volt_min} < conv_up) begin
      next_st.conv_cnt = 4'h0;
    end else if (st.conv_cnt >= CONV_HOLD) begin
      next_st.conv_on  = 1'b1;
      next_st.conv_cnt = 4'h0;
    end else if (tick_s) begin
      next_st.conv_cnt = st.conv_cnt + 4'h1;
    end

    // charging attempts while cell communication is lost
    if (!MEAS_I.comm_lost || !MEAS_I.charger) begin
      next_st.comm_cnt = 8'h00;
      if (!MEAS_I.comm_lost) begin
        next_st.cerr = 1'b0;
      end
    end else if (!st.cerr) begin
      if (!st.ctrl[CTRL_RESTORE] || st.comm_cnt >= par[4'd15]) begin
        next_st.cerr = 1'b1;
        ev[IRQ_CERR] = 1'b1;
      end else if (tick_s) begin
        next_st.comm_cnt = st.comm_cnt + 8'h01;
      end
    end

    // attempt pin falls in the same cycle the error is raised
    next_st.att_out = MEAS_I.charger && !next_st.cerr;

    // apb setup: capture read word of own registers
    if (setup) begin
      next_st.rd_mem = slot[4];
      unique case (1'b1)
        idx == IDX_CTRL: next_st.rd_own = {30'h0, st.ctrl};
        idx == IDX_STAT: next_st.rd_own = stat;
        idx == IDX_IRQ:  next_st.rd_own = {25'h0, st.irq};
        idx == IDX_MASK: next_st.rd_own = {25'h0, st.mask};
        default:         next_st.rd_own = 32'h00000000;
      endcase
    end

    // apb access: writes, and read of events clears them
    if (access && PWRITE) begin
      if (idx == IDX_CTRL) begin
        next_st.ctrl = PWDATA[1:0];
      end
      if (idx == IDX_MASK) begin
        next_st.mask = PWDATA[NIRQ-1:0];
      end
    end
    if (access && !PWRITE && idx == IDX_IRQ) begin
      // clear only what the setup cycle captured, so an event that
      // lands between setup and access is still reported later
      next_st.irq = st.irq & ~st.rd_own[NIRQ-1:0];
    end
    // an event in the clearing cycle survives
    next_st.irq = next_st.irq | ev;
  end

  // state registers
  // converter starts enabled so a cold start keeps the load fed
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      st <= '{pack: PK_OPEN, conv_on: 1'b1, irq: IRQ_RST[NIRQ-1:0],
              default: '0};
    end else begin
      st <= next_st;
    end
  end

  // apb answers: zero wait states, unmapped words flag an error
  // read data is registered in setup, so the access cycle never waits
  assign PREADY  = 1'b1;
  assign PSLVERR = access && !slot[4] && !own_hit;
  assign PRDATA  = st.rd_mem ? {24'h000000, bank_rd} : st.rd_own;

  // pins, all from state flops
  assign PRECHARGE_O      = st.pack == PK_PRE;
  assign MAIN_CONTACTOR_O = st.pack == PK_MAIN;
  assign CONVERTER_ENABLE_OUT_O = st.conv_on;
  assign CLIMATE_O        = st.clim_out;
  assign CHARGE_ATTEMPT_O = st.att_out;
  assign CHARGE_ERROR_O   = st.cerr;
  assign PROTECT_O        = st.prot;
  assign IRQ_O            = |(st.irq & st.mask);
endmodule : battery_protection_qualifier

// ### dv/bpq_sva.sv
// assertions on the top ports of the protection qualifier
`timescale 1ns/100ps
module bpq_sva import bpq_pkg::*; #(
  parameter int TICK_CYCLES = 10  // clocks per 0.1 s, unused here
) (
  // clock and reset
  input wire logic           CLOCK_I,
  input wire logic           RST_I,
  // measurements
  input wire bpq_pkg::meas_t MEAS_I,
  // outputs
  input wire logic           PRECHARGE_O,
  input wire logic           MAIN_CONTACTOR_O,
  input wire logic           CONVERTER_ENABLE_OUT_O,
  input wire logic           CLIMATE_O,
  input wire logic           CHARGE_ATTEMPT_O,
  input wire logic           CHARGE_ERROR_O,
  input wire logic [3:0]     PROTECT_O
);
  import bpq_pkg::*;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // main closes only straight out of precharge
  a_main_after_pre: assert property ($rose(MAIN_CONTACTOR_O) |-> $past(PRECHARGE_O)) else $error("main closed without precharge");
  a_pre_main_excl: assert property (!(PRECHARGE_O && MAIN_CONTACTOR_O)) else $error("precharge and main both on");
  a_ins_opens: assert property (PROTECT_O[0] |=> !PRECHARGE_O && !MAIN_CONTACTOR_O) else $error("pack kept closed on insulation fault");
  // insulation and sensor-loss protections move only with their condition
  a_ins_rise: assert property ($rose(PROTECT_O[0]) |-> $past(MEAS_I.ins_fault)) else $error("insulation rose without fault");
  a_ins_fall: assert property ($fell(PROTECT_O[0]) |-> !$past(MEAS_I.ins_fault)) else $error("insulation fell with fault");
  a_cur_rise: assert property ($rose(PROTECT_O[3]) |-> $past(MEAS_I.cur_missing)) else $error("sensor loss rose wrongly");
  a_cur_fall: assert property ($fell(PROTECT_O[3]) |-> !$past(MEAS_I.cur_missing)) else $error("sensor loss fell wrongly");
  // converter is only cut in passive state
  a_conv_active: assert property ((MEAS_I.charger || MEAS_I.ignition) [*2] |-> CONVERTER_ENABLE_OUT_O) else $error("converter off while active");
  a_conv_cut: assert property ($fell(CONVERTER_ENABLE_OUT_O) |-> !$past(MEAS_I.charger) && !$past(MEAS_I.ignition)) else $error("converter cut outside passive");
  // charge error stops attempts and needs lost cells
  a_err_stops: assert property (CHARGE_ERROR_O |-> !CHARGE_ATTEMPT_O) else $error("attempt during charge error");
  a_err_cause: assert property ($rose(CHARGE_ERROR_O) |-> $past(MEAS_I.comm_lost)) else $error("charge error without comm loss");
  a_climate_gate: assert property (CLIMATE_O |-> $past(MEAS_I.climate_req)) else $error("climate on without request");
endmodule : bpq_sva

// ### dv/bpq_plant.sv
// plant model: cell sensors, charger and ignition seen by the block
`timescale 1ns/100ps
module bpq_plant (
  // clock
  input  wire logic           CLOCK_I,
  // commanded plant state
  input  wire bpq_pkg::meas_t STATE_I,
  // sensor lines into the qualifier
  output bpq_pkg::meas_t      MEAS_O
);
  import bpq_pkg::*;
  // sensors report one clock late, never sooner than real ones
  always @(posedge CLOCK_I) begin
    MEAS_O <= STATE_I;
  end
endmodule : bpq_plant

// ### dv/battery_protection_qualifier_bench.sv
// self-checking bench for the battery protection qualifier
`timescale 1ns/100ps
module battery_protection_qualifier_bench;
  import bpq_pkg::*;
  localparam int TC = 10;  // clocks per 0.1 s, shortens every delay
  // settings used by the scenarios, one per bank slot
  localparam logic [7:0] CFG [NPARAM] = '{8'h02, 8'hFF, 8'h03, 8'h02,
    8'hC8, 8'hB4, 8'h00, 8'h00, 8'hD0, 8'hC0, 8'h01, 8'h00, 8'h50,
    8'h01, 8'h01, 8'h02};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h00000000;
  meas_t       cmd = '{temp_max: 8'h64, volt_min: 8'h80,
                       ignition: 1'b1, default: 1'b0};
  meas_t       meas;
  logic        pready, pslverr, pre, mainc, conv, clim, att, cerr, irq;
  logic [31:0] prdata;
  logic [3:0]  prot;
  logic [33:0] expq [$];  // check flag, slave error, data
  logic [33:0] mon_e;
  logic [31:0] rnd = 32'h00000008;
  int          err_count = 0;
  int          check_count = 0;

  battery_protection_qualifier #(.TICK_CYCLES(TC)) i_dut (
    .CLOCK_I(clk), .RST_I(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .MEAS_I(meas),
    .PRECHARGE_O(pre), .MAIN_CONTACTOR_O(mainc),
    .CONVERTER_ENABLE_OUT_O(conv), .CLIMATE_O(clim),
    .CHARGE_ATTEMPT_O(att), .CHARGE_ERROR_O(cerr), .PROTECT_O(prot),
    .IRQ_O(irq));
  bpq_plant i_plant (.CLOCK_I(clk), .STATE_I(cmd), .MEAS_O(meas));

  // free running clock, 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end

  // xorshift step for random bank data
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  endfunction : xs

  // byte address of a word index
  function automatic logic [11:0] ad(input logic [7:0] ix);
    ad = {2'b00, ix, 2'b00};
  endfunction : ad

  // output pin picked by number
  function automatic logic pin(input int k);
    case (k)
      0, 1, 2, 3: pin = prot[k];
      4: pin = pre;
      5: pin = mainc;
      6: pin = conv;
      default: pin = cerr;
    endcase
  endfunction : pin

  // single compare, counted
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // apb transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // read with its expectation noted first
  task rd(input logic [11:0] a, input logic [33:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h00000000);
  endtask : rd

  // bounded wait for a pin level, latency must fall in lo..hi
  task lat(input int k, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (pin(k) !== v && n <= hi) begin
      @(negedge clk);
      n++;
    end
    cmp($sformatf("latency pin %0d", k), 32'h1, {31'b0, n >= lo && n <= hi});
  endtask : lat

  // verdict and end of run
  task test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // read monitor: oldest note against each completed read
  always @(negedge clk) begin
    if (psel && pen && pready === 1'b1 && !pwr && expq.size() > 0) begin
      mon_e = expq.pop_front();
      if (mon_e[33]) begin
        cmp("prdata", mon_e[31:0], prdata);
        cmp("pslverr", {31'b0, mon_e[32]}, {31'b0, pslverr});
      end
    end
  end

  // watchdog, well past the few thousand cycles needed
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done;
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < NPARAM; i++) rd(ad(PARAM_IDX[i]), {2'b10, 24'h0, PARAM_RST});
    rd(ad(IDX_MASK), {2'b10, IRQ_RST});
    rd(12'h1D0, {2'b11, 32'h0});
    rd(12'h0F2, {2'b11, 32'h0});
    // random bank data, upper bits must read zero
    for (int i = 0; i < NPARAM; i++) begin
      rnd = xs(rnd);
      apb(1'b1, ad(PARAM_IDX[i]), rnd);
      rd(ad(PARAM_IDX[i]), {2'b10, 24'h0, rnd[7:0]});
    end
    for (int i = 0; i < NPARAM; i++) apb(1'b1, ad(PARAM_IDX[i]), {24'h0, CFG[i]});
    rd(ad(IDX_IRQ), 34'h0);
    apb(1'b1, ad(IDX_MASK), 32'h1);
    // fault interrupted after 15 clocks, then held
    @(posedge clk);
    cmd.ins_fault <= 1'b1;
    repeat (15) @(posedge clk);
    cmd.ins_fault <= 1'b0;
    repeat (5) @(posedge clk);
    cmd.ins_fault <= 1'b1;
    lat(0, 1'b1, 2 * TC, 4 * TC + 4);
    repeat (2) @(negedge clk);
    cmp("irq_o", 32'h1, {31'b0, irq});
    rd(ad(IDX_IRQ), {2'b10, 32'h1});
    @(negedge clk);
    cmp("irq_o", 32'h0, {31'b0, irq});
    @(posedge clk);
    cmd.ins_fault <= 1'b0;
    lat(0, 1'b0, 10 * TC, 30 * TC + 4);
    // thresholds: on at equal, hold between, off at off code
    for (int k = 1; k < 3; k++) begin
      @(posedge clk);
      cmd.temp_max <= (k == 1) ? 8'hC8 : 8'hD0;
      lat(k, 1'b1, 0, k * TC + 4);
      @(posedge clk);
      cmd.temp_max <= (k == 1) ? 8'hB5 : 8'hC1;
      repeat (20) @(negedge clk);
      cmp("hold", 32'h1, {31'b0, pin(k)});
      @(posedge clk);
      cmd.temp_max <= (k == 1) ? 8'hB4 : 8'hC0;
      lat(k, 1'b0, 0, 14);
    end
    @(posedge clk);
    cmd.temp_max <= 8'h64;
    cmd.cur_missing <= 1'b1;
    lat(3, 1'b1, 0, 2 * TC + 4);
    @(posedge clk);
    cmd.cur_missing <= 1'b0;
    lat(3, 1'b0, 0, 20 * TC + 4);
    // close the pack: precharge for 2 s, then main
    apb(1'b1, ad(IDX_CTRL), 32'h1);
    lat(4, 1'b1, 0, 3);
    lat(5, 1'b1, 10 * TC, 30 * TC + 4);
    cmp("precharge", 32'h0, {31'b0, pre});
    apb(1'b1, ad(IDX_CTRL), 32'h0);
    repeat (2) @(negedge clk);
    cmp("main", 32'h0, {31'b0, mainc});
    // passive state: cut below code, back 10 codes above for 10 s
    @(posedge clk);
    cmd.ignition <= 1'b0;
    cmd.volt_min <= 8'h4F;
    lat(6, 1'b0, 0, 4);
    @(posedge clk);
    cmd.volt_min <= 8'h59;
    repeat (120 * TC) @(negedge clk);
    cmp("converter", 32'h0, {31'b0, conv});
    @(posedge clk);
    cmd.volt_min <= 8'h5A;
    lat(6, 1'b1, 90 * TC, 110 * TC + 4);
    // lost cells while charging, restore for 2 s
    apb(1'b1, ad(IDX_CTRL), 32'h2);
    @(posedge clk);
    cmd.charger <= 1'b1;
    cmd.comm_lost <= 1'b1;
    cmd.climate_req <= 1'b1;
    repeat (3) @(negedge clk);
    cmp("climate", 32'h1, {31'b0, clim});
    cmp("attempt", 32'h1, {31'b0, att});
    lat(7, 1'b1, 10 * TC, 30 * TC + 4);
    @(negedge clk);
    cmp("attempt", 32'h0, {31'b0, att});
    @(posedge clk);
    cmd.comm_lost <= 1'b0;
    lat(7, 1'b0, 0, 4);
    test_done;
  end
endmodule : battery_protection_qualifier_bench

bind battery_protection_qualifier bpq_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .MEAS_I(MEAS_I),
  .PRECHARGE_O(PRECHARGE_O), .MAIN_CONTACTOR_O(MAIN_CONTACTOR_O),
  .CONVERTER_ENABLE_OUT_O(CONVERTER_ENABLE_OUT_O), .CLIMATE_O(CLIMATE_O),
  .CHARGE_ATTEMPT_O(CHARGE_ATTEMPT_O), .CHARGE_ERROR_O(CHARGE_ERROR_O),
  .PROTECT_O(PROTECT_O));
